// *** panel_param_edit_and_monitor.sv ***
/*
 panel_param_edit_and_monitor: key debounce, panel state machine for
 setting items and live readouts, parameter store with active copy,
 display registers, Avalon-MM slave.
 assumes keys are synchronous, active high while pressed, and a single
 clock and reset.
*/
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module panel_param_edit_and_monitor #(
  parameter int N_PARAM = 8,
  parameter logic [7:0] FUNC_MASK = 8'h0f,
  parameter logic [31:0] ADJ_MAX = panel_pkg::ADJ_MAX_DEF,
  parameter int HOLD_CYC = panel_pkg::HOLD_CYCLES,
  parameter int DEB_CYC = panel_pkg::DEBOUNCE_CYCLES,
  parameter int RPT_CYC = panel_pkg::REPEAT_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // front panel keys
  input wire logic key_mode,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_left,
  // drive restart pulse
  input wire logic drive_restart,
  // live values
  input wire logic [31:0] mon_speed,
  input wire logic [31:0] mon_torque,
  input wire logic [31:0] mon_angle,
  input wire logic [31:0] mon_ref_cnt,
  input wire logic [31:0] mon_dev_cnt,
  input wire logic [31:0] mon_ref_pulse,
  input wire logic [4:0] in_terms,
  input wire logic probe_input_one,
  input wire logic probe_input_two,
  input wire logic [2:0] out_switch,
  input wire logic [2:0] out_invert,
  // display
  output logic [6:0] disp_state,
  output logic [31:0] disp_data,
  output logic [7:0] disp_seg,
  output logic [1:0] disp_cursor,
  output logic disp_group,
  output logic disp_blink,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int IW = $clog2(N_PARAM);
  localparam int HW = $clog2(HOLD_CYC);
  localparam int DW = $clog2(DEB_CYC);

  function automatic logic [31:0] bcd_step(input logic [31:0] v,
                                           input logic up);
    logic [31:0] r;
    logic c;
    logic [3:0] d;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 8; i++) begin
      d = v[i*4 +: 4];
      if (c) begin
        if (up) begin
          if (d == 4'h9) d = 4'h0;
          else begin
            d = d + 4'h1;
            c = 1'b0;
          end
        end else begin
          if (d == 4'h0) d = 4'h9;
          else begin
            d = d - 4'h1;
            c = 1'b0;
          end
        end
      end
      r[i*4 +: 4] = d;
    end
    return r;
  endfunction

  // key conditioning
  wire logic [3:0] key_raw = {key_left, key_down, key_up, key_mode};
  logic [3:0] press_p, rel_short, hold_p, rpt_p;
  genvar k;
  generate
    for (k = 0; k < panel_pkg::NUM_KEYS; k++) begin : g_key
      logic [DW-1:0] deb_cnt_r;
      logic [HW-1:0] hold_cnt_r;
      logic stable_r, stable_d_r, held_r;
      wire logic tick = stable_r && (hold_cnt_r == HW'(HOLD_CYC - 1));
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          deb_cnt_r <= '0;
          stable_r <= 1'b0;
          stable_d_r <= 1'b0;
        end else begin
          stable_d_r <= stable_r;
          if (key_raw[k] == stable_r) deb_cnt_r <= '0;
          else if (deb_cnt_r == DW'(DEB_CYC - 1)) begin
            stable_r <= key_raw[k];
            deb_cnt_r <= '0;
          end else deb_cnt_r <= deb_cnt_r + 1'b1;
        end
      end
      // after the first hold tick the count restarts one repeat short
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          hold_cnt_r <= '0;
          held_r <= 1'b0;
        end else if (!stable_r) begin
          hold_cnt_r <= '0;
          held_r <= 1'b0;
        end else if (tick) begin
          hold_cnt_r <= HW'(HOLD_CYC - RPT_CYC);
          held_r <= 1'b1;
        end else hold_cnt_r <= hold_cnt_r + 1'b1;
      end
      assign press_p[k] = stable_r & ~stable_d_r;
      assign rel_short[k] = ~stable_r & stable_d_r & ~held_r;
      assign hold_p[k] = tick & ~held_r;
      assign rpt_p[k] = tick & held_r;
    end
  endgenerate

  // one event per cycle: mode, left, up, down
  wire logic ev_mode = press_p[panel_pkg::KEY_MODE];
  wire logic ev_lshort = rel_short[panel_pkg::KEY_LEFT] & ~ev_mode;
  wire logic ev_lhold = hold_p[panel_pkg::KEY_LEFT] & ~ev_mode;
  wire logic ev_left_any = ev_lshort | ev_lhold;
  wire logic hi_busy = ev_mode | ev_left_any;
  wire logic ev_up = press_p[panel_pkg::KEY_UP] & ~hi_busy;
  wire logic rep_up = rpt_p[panel_pkg::KEY_UP] & ~hi_busy;
  wire logic any_up = ev_up | rep_up;
  wire logic ev_down = press_p[panel_pkg::KEY_DOWN] & ~hi_busy & ~any_up;
  wire logic rep_down = rpt_p[panel_pkg::KEY_DOWN] & ~hi_busy & ~any_up;

  // state
  panel_pkg::panel_state_t state_r, state_nxt;
  logic [IW-1:0] item_r, item_nxt, bidx_r;
  logic [2:0] cursor_r, cursor_nxt;
  logic [3:0] mon_idx_r, mon_idx_nxt;
  logic [31:0] param_r [N_PARAM];
  logic [31:0] act_r [N_PARAM];

  wire logic is_func = FUNC_MASK[item_r];
  wire logic [31:0] cur_val = param_r[item_r];
  wire logic [3:0] cur_digit = cur_val[{cursor_r, 2'b00} +: 4];
  wire logic [3:0] digit_inc = (cur_digit == 4'h9) ? 4'h0 : cur_digit + 4'h1;
  wire logic [IW-1:0] item_up = (item_r == IW'(N_PARAM - 1)) ? '0 :
                                item_r + 1'b1;
  wire logic [IW-1:0] item_dn = (item_r == '0) ? IW'(N_PARAM - 1) :
                                item_r - 1'b1;
  wire logic [3:0] mon_up = (mon_idx_r == 4'(panel_pkg::MON_COUNT - 1)) ?
                            4'h0 : mon_idx_r + 4'h1;
  wire logic [3:0] mon_dn = (mon_idx_r == 4'h0) ?
                            4'(panel_pkg::MON_COUNT - 1) : mon_idx_r - 4'h1;
  wire logic [7:0] mon_num = panel_pkg::MON_TABLE[mon_idx_r];
  logic panel_we;
  logic [31:0] panel_val;

  always_comb begin
    state_nxt = state_r;
    item_nxt = item_r;
    cursor_nxt = cursor_r;
    mon_idx_nxt = mon_idx_r;
    panel_we = 1'b0;
    panel_val = cur_val;
    case (state_r)
      panel_pkg::ST_STATUS: begin
        if (ev_mode) state_nxt = panel_pkg::ST_PSEL;
      end
      panel_pkg::ST_PSEL: begin
        if (ev_mode) state_nxt = panel_pkg::ST_MSEL;
        else if (ev_lshort) begin
          state_nxt = panel_pkg::ST_PVAL;
          cursor_nxt = 3'h0;
        end else if (ev_up) item_nxt = item_up;
        else if (ev_down) item_nxt = item_dn;
      end
      panel_pkg::ST_PVAL: begin
        if (ev_mode) state_nxt = panel_pkg::ST_PSEL;
        else if (is_func) begin
          if (ev_lhold) begin
            state_nxt = panel_pkg::ST_EDIT;
            cursor_nxt = 3'h0;
          end else if (ev_lshort) state_nxt = panel_pkg::ST_PSEL;
        end else begin
          if (ev_lshort) state_nxt = panel_pkg::ST_PSEL;
          else if (any_up && cur_val < ADJ_MAX) begin
            panel_we = 1'b1;
            panel_val = bcd_step(cur_val, 1'b1);
          end else if ((ev_down || rep_down) && cur_val != '0) begin
            panel_we = 1'b1;
            panel_val = bcd_step(cur_val, 1'b0);
          end
        end
      end
      panel_pkg::ST_EDIT: begin
        if (ev_mode) state_nxt = panel_pkg::ST_PSEL;
        else if (ev_lhold) state_nxt = panel_pkg::ST_PVAL;
        else if (ev_lshort) cursor_nxt = cursor_r + 3'h1;
        else if (ev_up) begin
          panel_we = 1'b1;
          panel_val[{cursor_r, 2'b00} +: 4] = digit_inc;
        end
      end
      panel_pkg::ST_MSEL: begin
        if (ev_mode) state_nxt = panel_pkg::ST_UTIL;
        else if (ev_lshort) state_nxt = panel_pkg::ST_MVAL;
        else if (ev_up) mon_idx_nxt = mon_up;
        else if (ev_down) mon_idx_nxt = mon_dn;
      end
      panel_pkg::ST_MVAL: begin
        if (ev_mode || ev_lshort) state_nxt = panel_pkg::ST_MSEL;
      end
      panel_pkg::ST_UTIL: begin
        if (ev_mode) state_nxt = panel_pkg::ST_STATUS;
      end
      default: state_nxt = panel_pkg::ST_STATUS;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= panel_pkg::ST_STATUS;
      item_r <= '0;
      cursor_r <= 3'h0;
      mon_idx_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      item_r <= item_nxt;
      cursor_r <= cursor_nxt;
      mon_idx_r <= mon_idx_nxt;
    end
  end

  // bus slave: one wait cycle, then the answer
  logic ack_r;
  logic [31:0] rdata_r;
  wire logic bus_req = avs_read | avs_write;
  wire logic bus_wr = avs_write & ack_r;
  wire logic wr_value = bus_wr && (avs_address == panel_pkg::REG_VALUE);
  wire logic wr_index = bus_wr && (avs_address == panel_pkg::REG_INDEX);
  logic [31:0] be_mask, bus_val;
  always_comb begin
    for (int b = 0; b < 4; b++) be_mask[b*8 +: 8] = {8{avs_byteenable[b]}};
    bus_val = (param_r[bidx_r] & ~be_mask) | (avs_writedata & be_mask);
  end

  // parameter store: a bus write wins over a panel edit in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N_PARAM; i++) param_r[i] <= panel_pkg::PARAM_RESET;
    end else if (wr_value) param_r[bidx_r] <= bus_val;
    else if (panel_we) param_r[item_r] <= panel_val;
  end

  genvar p;
  generate
    for (p = 0; p < N_PARAM; p++) begin : g_act
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) act_r[p] <= panel_pkg::PARAM_RESET;
        else if (drive_restart) act_r[p] <= param_r[p];
      end
    end
  endgenerate
  wire logic [31:0] act_sel = FUNC_MASK[bidx_r] ? act_r[bidx_r] :
                              param_r[bidx_r];

  wire logic [31:0] stat_word = (32'(state_r) << panel_pkg::STAT_STATE_LSB) |
    (32'(cursor_r) << panel_pkg::STAT_CURSOR_LSB) |
    (32'(item_r) << panel_pkg::STAT_ITEM_LSB);
  logic [31:0] rd_mux;
  logic [7:0] seg_nxt;
  always_comb begin
    case (avs_address)
      panel_pkg::REG_STATUS: rd_mux = stat_word;
      panel_pkg::REG_INDEX: rd_mux = 32'(bidx_r);
      panel_pkg::REG_VALUE: rd_mux = param_r[bidx_r];
      panel_pkg::REG_ACTIVE: rd_mux = act_sel;
      panel_pkg::REG_MONITOR: rd_mux = 32'(mon_num) |
        (32'(seg_nxt) << panel_pkg::MONR_SEG_LSB);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      bidx_r <= '0;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (avs_read && !ack_r) rdata_r <= rd_mux;
      if (wr_index) bidx_r <= avs_writedata[IW-1:0];
    end
  end
  assign avs_waitrequest = bus_req & ~ack_r;
  assign avs_readdata = rdata_r;

  // display; live readouts are always selectable, servo state is not used
  logic [31:0] data_nxt;
  always_comb begin
    seg_nxt = 8'h00;
    data_nxt = 32'h0000_0000;
    case (mon_num)
      panel_pkg::MON_SPEED: data_nxt = mon_speed;
      panel_pkg::MON_TORQUE: data_nxt = mon_torque;
      panel_pkg::MON_ANGLE: data_nxt = mon_angle;
      panel_pkg::MON_REF_CNT: data_nxt = mon_ref_cnt;
      panel_pkg::MON_DEV_CNT: data_nxt = mon_dev_cnt;
      panel_pkg::MON_REF_PULSE: data_nxt = mon_ref_pulse;
      panel_pkg::MON_INPUTS: seg_nxt[4:0] = ~in_terms;
      panel_pkg::MON_PROBE: seg_nxt[7:6] = {probe_input_two,
                                            probe_input_one};
      panel_pkg::MON_OUTPUTS:
        seg_nxt[2:0] = out_switch ^ out_invert;
      default: data_nxt = 32'h0000_0000;
    endcase
    if (state_r != panel_pkg::ST_MVAL) seg_nxt = 8'h00;
    case (state_r)
      panel_pkg::ST_PSEL: data_nxt = 32'(item_r);
      panel_pkg::ST_PVAL,
      panel_pkg::ST_EDIT:
        data_nxt = 32'(cur_val[{cursor_r[2], 4'h0} +: 16]);
      panel_pkg::ST_MSEL: data_nxt = 32'(mon_num);
      panel_pkg::ST_MVAL: data_nxt = data_nxt;
      default: data_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      disp_data <= 32'h0000_0000;
      disp_seg <= 8'h00;
    end else begin
      disp_data <= data_nxt;
      disp_seg <= seg_nxt;
    end
  end
  assign disp_state = state_r;
  assign disp_cursor = cursor_r[1:0];
  assign disp_group = cursor_r[2];
  assign disp_blink = (state_r == panel_pkg::ST_EDIT);

  // checks
  a_mode_cycle: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == panel_pkg::ST_PSEL && ev_mode) |=>
      state_r == panel_pkg::ST_MSEL) else $error("mode order broken");
  a_item_step: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == panel_pkg::ST_PSEL && ev_up) |=> item_r == $past(item_up))
    else $error("item did not step up");
  a_value_show: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == panel_pkg::ST_PSEL && ev_lshort) |=>
      state_r == panel_pkg::ST_PVAL ##1 disp_data == 32'(cur_val[15:0]))
    else $error("value not shown");
  a_edit_entry: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == panel_pkg::ST_PVAL && is_func && ev_lhold) |=>
      disp_blink && cursor_r == 3'h0) else $error("edit not entered");
  a_cursor_move: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == panel_pkg::ST_EDIT && ev_lshort) |=>
      cursor_r == $past(cursor_r) + 3'h1) else $error("cursor stuck");
  a_digit_inc: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == panel_pkg::ST_EDIT && ev_up && !wr_value) |=>
      cur_digit == $past(digit_inc)) else $error("digit not raised");
  a_edit_exit: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == panel_pkg::ST_EDIT && ev_mode) |=>
      state_r == panel_pkg::ST_PSEL) else $error("edit exit wrong");
  a_active_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !drive_restart |=> $stable(act_r[1])) else $error("active changed");
  a_adj_return: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == panel_pkg::ST_PVAL && !is_func && ev_lshort) |=>
      state_r == panel_pkg::ST_PSEL) else $error("adjust return wrong");
  a_input_seg: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == panel_pkg::ST_MVAL && mon_num == panel_pkg::MON_INPUTS) |=>
      disp_seg[4:0] == ~$past(in_terms)) else $error("input segs wrong");
  a_output_seg: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == panel_pkg::ST_MVAL && mon_num == panel_pkg::MON_OUTPUTS) |=>
      disp_seg[2:0] == $past(out_switch ^ out_invert))
    else $error("output segs wrong");
  a_bus_answer: assert property (@(posedge sys_clk) disable iff (rst)
    ($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest ##1
      !avs_waitrequest) else $error("bus answer late");
  c_edit: cover property (@(posedge sys_clk) disable iff (rst)
    state_r == panel_pkg::ST_EDIT && ev_up);
  c_repeat: cover property (@(posedge sys_clk) disable iff (rst)
    state_r == panel_pkg::ST_PVAL && rep_up);
  c_monitor: cover property (@(posedge sys_clk) disable iff (rst)
    state_r == panel_pkg::ST_MVAL);
  c_restart: cover property (@(posedge sys_clk) disable iff (rst)
    drive_restart);
endmodule // panel_param_edit_and_monitor
`default_nettype wire

// *** panel_pkg.sv ***
/*
 panel_pkg: shared constants of the front-panel controller: key indices,
 display states, register map, field positions, reset values, timing.
 assumes a 50 MHz system clock.
*/
`default_nettype none
package panel_pkg;
  // clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int HOLD_TIME_MS = 1000;
  localparam int DEBOUNCE_MS = 10;
  localparam int REPEAT_MS = 100;
  localparam int HOLD_CYCLES = HOLD_TIME_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int REPEAT_CYCLES = REPEAT_MS * (CLK_HZ / 1000);
  // key indices
  localparam int KEY_MODE = 0;
  localparam int KEY_UP = 1;
  localparam int KEY_DOWN = 2;
  localparam int KEY_LEFT = 3;
  localparam int NUM_KEYS = 4;
  // panel states, one-hot
  typedef enum logic [6:0] {
    ST_STATUS = 7'h01,
    ST_PSEL = 7'h02,
    ST_PVAL = 7'h04,
    ST_EDIT = 7'h08,
    ST_MSEL = 7'h10,
    ST_MVAL = 7'h20,
    ST_UTIL = 7'h40
  } panel_state_t;
  // register byte offsets
  localparam logic [4:0] REG_STATUS = 5'h00;
  localparam logic [4:0] REG_INDEX = 5'h04;
  localparam logic [4:0] REG_VALUE = 5'h08;
  localparam logic [4:0] REG_ACTIVE = 5'h0c;
  localparam logic [4:0] REG_MONITOR = 5'h10;
  // status and monitor register field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_CURSOR_LSB = 8;
  localparam int STAT_ITEM_LSB = 16;
  localparam int MONR_SEG_LSB = 8;
  // reset values and default adjust limit
  localparam logic [31:0] PARAM_RESET = 32'h0000_0000;
  localparam logic [31:0] ADJ_MAX_DEF = 32'h0009_9999;
  // live readout item numbers, index 0 first
  localparam int MON_COUNT = 9;
  localparam logic [7:0] MON_SPEED = 8'h00;
  localparam logic [7:0] MON_TORQUE = 8'h03;
  localparam logic [7:0] MON_ANGLE = 8'h04;
  localparam logic [7:0] MON_INPUTS = 8'h05;
  localparam logic [7:0] MON_PROBE = 8'h06;
  localparam logic [7:0] MON_OUTPUTS = 8'h07;
  localparam logic [7:0] MON_REF_CNT = 8'h09;
  localparam logic [7:0] MON_DEV_CNT = 8'h0b;
  localparam logic [7:0] MON_REF_PULSE = 8'h0d;
  localparam logic [8:0][7:0] MON_TABLE = {MON_REF_PULSE, MON_DEV_CNT,
    MON_REF_CNT, MON_OUTPUTS, MON_PROBE, MON_INPUTS, MON_ANGLE, MON_TORQUE,
    MON_SPEED};
endpackage
`default_nettype wire

// *** panel_operator.sv ***
/*
 panel_operator: the person at the four front keys, with contact bounce.
 assumes the keys are sampled on sys_clk and active high while pressed.
*/
`timescale 1ns/1ps
`default_nettype none
module panel_operator #(
  parameter int DEB = 4
) (
  // clock
  input wire logic sys_clk,
  // keys
  output logic key_mode,
  output logic key_up,
  output logic key_down,
  output logic key_left
);
  logic [3:0] keys_r = 4'h0;
  assign {key_left, key_down, key_up, key_mode} = keys_r;
  // chatter shorter than the filter, then a steady press and release
  task automatic press(input int k, input int cyc);
    begin
      repeat (2) begin
        @(posedge sys_clk) keys_r[k] <= 1'b1;
        @(posedge sys_clk) keys_r[k] <= 1'b0;
      end
      @(posedge sys_clk) keys_r[k] <= 1'b1;
      repeat (cyc) @(posedge sys_clk);
      keys_r[k] <= 1'b0;
      repeat (DEB + 8) @(posedge sys_clk);
    end
  endtask
endmodule // panel_operator
`default_nettype wire

// *** panel_param_edit_and_monitor_tb.sv ***
/*
 panel_param_edit_and_monitor_tb: key walks, bus accesses, readouts.
 assumes short filter and hold counts set at the design instance.
*/
`timescale 1ns/1ps
`default_nettype none
module panel_param_edit_and_monitor_tb;
  localparam int HOLD = 64;
  localparam int DEB = 4;
  logic sys_clk, rst, drive_restart, key_mode, key_up, key_down, key_left;
  logic [31:0] mon_v [6];
  logic [4:0] in_terms;
  logic probe_input_one, probe_input_two;
  logic [2:0] out_switch, out_invert;
  logic [6:0] disp_state;
  logic [31:0] disp_data, avs_writedata, avs_readdata, rd;
  logic [7:0] disp_seg;
  logic [1:0] disp_cursor;
  logic disp_group, disp_blink, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  int errors, n_checks;
  integer seed;

  panel_param_edit_and_monitor #(.HOLD_CYC(HOLD), .DEB_CYC(DEB),
    .RPT_CYC(16)) panel_param_edit_and_monitor_i (.sys_clk(sys_clk),
    .rst(rst), .key_mode(key_mode), .key_up(key_up), .key_down(key_down),
    .key_left(key_left), .drive_restart(drive_restart),
    .mon_speed(mon_v[0]), .mon_torque(mon_v[1]), .mon_angle(mon_v[2]),
    .mon_ref_cnt(mon_v[3]), .mon_dev_cnt(mon_v[4]),
    .mon_ref_pulse(mon_v[5]), .in_terms(in_terms),
    .probe_input_one(probe_input_one), .probe_input_two(probe_input_two),
    .out_switch(out_switch), .out_invert(out_invert),
    .disp_state(disp_state), .disp_data(disp_data), .disp_seg(disp_seg),
    .disp_cursor(disp_cursor), .disp_group(disp_group),
    .disp_blink(disp_blink), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  panel_operator #(.DEB(DEB)) panel_operator_i (.sys_clk(sys_clk),
    .key_mode(key_mode), .key_up(key_up), .key_down(key_down),
    .key_left(key_left));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_checks++;
      if (seen !== exp) begin
        errors++;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task automatic results;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask

  // request held until waitrequest is seen low at a rising edge; values
  // read right after the edge are those the design sampled at that edge
  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] wd);
    int n;
    begin
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= wd;
      n = 0;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
        @(posedge sys_clk);
        n++;
      end
      rd = avs_readdata;
      if (n >= 20) begin
        errors++;
        results();
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // one idle edge so the next call never reassigns in this time step
      @(posedge sys_clk);
    end
  endtask

  task automatic kp(input int k, input int n);
    repeat (n) panel_operator_i.press(k, 12);
  endtask

  task automatic kh(input int k);
    panel_operator_i.press(k, HOLD + DEB + 4);
  endtask

  // readout value by table position; segment readouts give none
  function automatic logic [31:0] val_exp(input int i);
    case (i)
      0, 1, 2: return mon_v[i];
      6, 7, 8: return mon_v[i - 3];
      default: return 32'h0;
    endcase
  endfunction

  function automatic logic [7:0] seg_exp(input int i);
    case (i)
      3: return {3'h0, ~in_terms};
      4: return {probe_input_two, probe_input_one, 6'h00};
      5: return {5'h00, out_switch ^ out_invert};
      default: return 8'h00;
    endcase
  endfunction

  initial begin
    seed = 32'h19f646d2;
    errors = 0;
    n_checks = 0;
    rst = 1'b1;
    drive_restart = 1'b0;
    foreach (mon_v[j]) mon_v[j] = 32'h0;
    {in_terms, probe_input_one, probe_input_two} = 7'h00;
    {out_switch, out_invert} = 6'h00;
    {avs_address, avs_read, avs_write, avs_writedata} = 39'h0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk(32'(disp_state), 32'h01);
    kp(panel_pkg::KEY_MODE, 1);
    chk(32'(disp_state), 32'h02);
    kp(panel_pkg::KEY_UP, 2);
    chk(disp_data, 32'h2);
    kp(panel_pkg::KEY_DOWN, 1);
    chk(disp_data, 32'h1);
    kp(panel_pkg::KEY_LEFT, 1);
    chk(32'(disp_state), 32'h04);
    kh(panel_pkg::KEY_LEFT);
    chk(32'({disp_state, disp_blink, disp_cursor}), 32'h044);
    kp(panel_pkg::KEY_UP, 2);
    chk(disp_data, 32'h2);
    kp(panel_pkg::KEY_LEFT, 1);
    chk(32'(disp_cursor), 32'h1);
    kp(panel_pkg::KEY_UP, 3);
    chk(disp_data, 32'h32);
    kp(panel_pkg::KEY_LEFT, 3);
    chk(32'({disp_group, disp_cursor}), 32'h4);
    kp(panel_pkg::KEY_UP, 1);
    chk(disp_data, 32'h1);
    kh(panel_pkg::KEY_LEFT);
    chk(32'(disp_state), 32'h04);
    bus(1'b1, panel_pkg::REG_INDEX, 32'h1);
    bus(1'b0, panel_pkg::REG_VALUE, 32'h0);
    chk(rd, 32'h00010032);
    bus(1'b0, panel_pkg::REG_ACTIVE, 32'h0);
    chk(rd, 32'h0);
    drive_restart <= 1'b1;
    @(posedge sys_clk) drive_restart <= 1'b0;
    bus(1'b0, panel_pkg::REG_ACTIVE, 32'h0);
    chk(rd, 32'h00010032);
    kh(panel_pkg::KEY_LEFT);
    kp(panel_pkg::KEY_MODE, 1);
    chk(32'(disp_state), 32'h02);
    kp(panel_pkg::KEY_UP, 3);
    kp(panel_pkg::KEY_LEFT, 1);
    kp(panel_pkg::KEY_UP, 1);
    chk(disp_data, 32'h1);
    panel_operator_i.press(panel_pkg::KEY_UP, HOLD + 56);
    chk(disp_data, 32'h5);
    kp(panel_pkg::KEY_DOWN, 1);
    chk(disp_data, 32'h4);
    bus(1'b1, panel_pkg::REG_INDEX, 32'h4);
    bus(1'b1, panel_pkg::REG_VALUE, panel_pkg::ADJ_MAX_DEF);
    kp(panel_pkg::KEY_UP, 1);
    bus(1'b0, panel_pkg::REG_VALUE, 32'h0);
    chk(rd, panel_pkg::ADJ_MAX_DEF);
    kp(panel_pkg::KEY_MODE, 1);
    chk(32'(disp_state), 32'h02);
    kp(panel_pkg::KEY_LEFT, 2);
    chk(32'(disp_state), 32'h02);
    kp(panel_pkg::KEY_MODE, 1);
    chk(32'(disp_state), 32'h10);
    for (int i = 0; i < 9; i++) begin
      foreach (mon_v[j]) mon_v[j] <= $random(seed);
      {in_terms, probe_input_one, probe_input_two} <= 7'($random(seed));
      {out_switch, out_invert} <= 6'($random(seed));
      chk(disp_data, 32'(panel_pkg::MON_TABLE[i]));
      kp(panel_pkg::KEY_LEFT, 1);
      chk(32'(disp_state), 32'h20);
      if (i < 3 || i > 5) begin
        chk(disp_data, val_exp(i));
      end
      chk(32'(disp_seg), 32'(seg_exp(i)));
      kp(panel_pkg::KEY_LEFT, 1);
      chk(32'(disp_state), 32'h10);
      kp(panel_pkg::KEY_UP, 1);
    end
    chk(disp_data, 32'h0);
    kp(panel_pkg::KEY_DOWN, 1);
    chk(disp_data, 32'(panel_pkg::MON_REF_PULSE));
    kp(panel_pkg::KEY_MODE, 1);
    chk(32'(disp_state), 32'h40);
    kp(panel_pkg::KEY_MODE, 1);
    chk(32'(disp_state), 32'h01);
    bus(1'b0, 5'h14, 32'h0);
    chk(rd, 32'h0);
    results();
  end
endmodule // panel_param_edit_and_monitor_tb
`default_nettype wire
